// ### bench/expansion_bus_mac_arbiter_tb.sv
`timescale 1ns/1ps
module expansion_bus_mac_arbiter_tb;
    import xbus_pkg::*;
    localparam int TICK = 2 * HALF_BIT_CYCLES;
    logic clk_i;
    logic resetn_i;
    logic mac_transmit_request_i;
    logic mac_tx_serial_i;
    logic [REP_COUNT-1:0] rx_active_i;
    logic [REP_COUNT-1:0] rx_data_i;
    logic [REP_COUNT-1:0] net_tx_data_o;
    logic [REP_COUNT-1:0] net_jam_o;
    logic mac_tx_ready_o;
    logic mac_rx_serial_o;
    logic mac_receive_enable_o;
    logic mac_receive_clock_o;
    logic mac_transmit_clock_o;
    logic mac_collision_detect_o;
    logic sync_reset_n_o;
    logic bc;
    int fails;
    int check_count;

    xbus_if #(.N(REP_COUNT)) xbus_if_i (.clk_i(clk_i));
    xbus_arbiter #(.N(REP_COUNT)) xbus_arbiter_i (.clk_i(clk_i), .resetn_i(resetn_i),
        .bus(xbus_if_i), .mac_transmit_request_i(mac_transmit_request_i),
        .mac_tx_serial_i(mac_tx_serial_i), .mac_tx_ready_o(mac_tx_ready_o),
        .mac_rx_serial_o(mac_rx_serial_o), .mac_receive_enable_o(mac_receive_enable_o),
        .mac_receive_clock_o(mac_receive_clock_o), .mac_transmit_clock_o(mac_transmit_clock_o),
        .mac_collision_detect_o(mac_collision_detect_o), .sync_reset_n_o(sync_reset_n_o));
    xbus_repeaters #(.N(REP_COUNT)) xbus_repeaters_i (.clk_i(clk_i), .resetn_i(resetn_i),
        .bus(xbus_if_i), .rx_active_i(rx_active_i), .rx_data_i(rx_data_i),
        .net_tx_data_o(net_tx_data_o), .net_jam_o(net_jam_o));
    xbus_sva #(.N(REP_COUNT)) xbus_sva_i (.clk_i(clk_i), .resetn_i(resetn_i),
        .req_n(xbus_if_i.req_n), .grant_n(xbus_if_i.grant_n),
        .collision_n(xbus_if_i.collision_n), .rep_dat_oe_n(xbus_if_i.rep_dat_oe_n),
        .bit_clock(xbus_if_i.bit_clock), .sync_reset_n(xbus_if_i.sync_reset_n),
        .mac_transmit_request_i(mac_transmit_request_i),
        .mac_collision_detect_o(mac_collision_detect_o));

    initial
    begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic ticks(input int n);
        repeat (n * TICK) @(posedge clk_i);
    endtask

    // Counts whole bit times until collision detect is released.
    task automatic wait_cdt_low(input int limit, output int n);
        n = 0;
        while (mac_collision_detect_o !== 1'b0)
        begin
            if (n == limit)
            begin
                fails++;
                close_out();
            end
            ticks(1);
            n++;
        end
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_idle();
        ticks(2);
        #1;
        check(sync_reset_n_o, 1'b1);
        check(mac_collision_detect_o, 1'b0);
        check({xbus_if_i.grant_n, xbus_if_i.collision_n}, 2'b11);
        repeat (24)
        begin
            @(negedge clk_i);
            bc = xbus_if_i.bit_clock;
            @(posedge clk_i);
            #1;
            check(mac_transmit_clock_o, bc);
        end
    endtask

    task automatic t_single();
        int n;
        @(posedge clk_i);
        rx_data_i <= 3'b001;
        rx_active_i <= 3'b001;
        ticks(3);
        #1;
        check({xbus_if_i.grant_n, xbus_if_i.collision_n}, 2'b01);
        check({xbus_if_i.serial_bus_line, net_tx_data_o}, 4'hf);
        check({mac_receive_enable_o, mac_rx_serial_o, mac_receive_clock_o ^ mac_transmit_clock_o}, 3'h7);
        ticks(1);
        rx_data_i <= 3'b000;
        ticks(3);
        #1;
        check({xbus_if_i.serial_bus_line, mac_rx_serial_o}, 2'b00);
        ticks(100);
        rx_active_i <= 3'b000;
        ticks(3);
        #1;
        check({xbus_if_i.grant_n, net_jam_o}, 4'h8);
        wait_cdt_low(200, n);
    endtask

    task automatic t_fragment();
        int n;
        ticks(1);
        rx_active_i <= 3'b010;
        ticks(20);
        rx_active_i <= 3'b000;
        ticks(3);
        #1;
        check({xbus_if_i.req_n, net_jam_o}, 6'h3f);
        ticks(87);
        #1;
        check(net_jam_o, 3'b101);
        ticks(10);
        #1;
        check(net_jam_o, 3'b000);
        wait_cdt_low(200, n);
    endtask

    task automatic t_collision();
        int n;
        ticks(1);
        rx_active_i <= 3'b101;
        ticks(3);
        #1;
        check({xbus_if_i.grant_n, xbus_if_i.collision_n}, 2'b10);
        check({net_jam_o[0], net_jam_o[2]}, 2'b11);
        check(mac_collision_detect_o, 1'b1);
        ticks(37);
        rx_active_i <= 3'b000;
        wait_cdt_low(200, n);
        check(n >= 50 && n <= 60, 1'b1);
        ticks(100);
    endtask

    task automatic t_mac();
        int n;
        ticks(1);
        rx_active_i <= 3'b001;
        ticks(3);
        mac_transmit_request_i <= 1'b1;
        mac_tx_serial_i <= 1'b1;
        ticks(3);
        #1;
        check({xbus_if_i.grant_n, xbus_if_i.collision_n}, 2'b10);
        ticks(12);
        #1;
        check({mac_tx_ready_o, mac_collision_detect_o}, 2'b01);
        ticks(1);
        mac_transmit_request_i <= 1'b0;
        ticks(40);
        mac_transmit_request_i <= 1'b1;
        ticks(3);
        mac_transmit_request_i <= 1'b0;
        wait_cdt_low(200, n);
        check(n >= 88 && n <= 98, 1'b1);
        rx_active_i <= 3'b000;
        ticks(3);
        mac_transmit_request_i <= 1'b1;
        mac_tx_serial_i <= 1'b0;
        ticks(3);
        #1;
        check({xbus_if_i.grant_n, xbus_if_i.serial_bus_line}, 2'b01);
        ticks(12);
        #1;
        check({mac_tx_ready_o, xbus_if_i.serial_bus_line}, 2'b10);
        ticks(1);
        mac_transmit_request_i <= 1'b0;
        ticks(100);
    endtask

    task automatic t_midreset();
        @(posedge clk_i);
        rx_active_i <= 3'b001;
        ticks(5);
        resetn_i <= 1'b0;
        @(posedge clk_i);
        #1;
        check({sync_reset_n_o, xbus_if_i.grant_n, mac_collision_detect_o}, 3'b010);
        @(posedge clk_i);
        rx_active_i <= 3'b000;
        resetn_i <= 1'b1;
        ticks(2);
        #1;
        check(sync_reset_n_o, 1'b1);
    endtask

    initial
    begin
        repeat (100000) @(posedge clk_i);
        fails++;
        close_out();
    end

    initial
    begin
        fails = 0;
        check_count = 0;
        resetn_i = 1'b0;
        mac_transmit_request_i = 1'b0;
        mac_tx_serial_i = 1'b0;
        rx_active_i = 3'b000;
        rx_data_i = 3'b000;
        repeat (4) @(posedge clk_i);
        #1;
        check({sync_reset_n_o, xbus_if_i.grant_n}, 2'b01);
        @(posedge clk_i);
        resetn_i <= 1'b1;
        t_idle();
        t_single();
        t_fragment();
        t_collision();
        t_mac();
        t_midreset();
        close_out();
    end
endmodule

// ### bench/xbus_sva.sv
`timescale 1ns/1ps
module xbus_sva
    import xbus_pkg::*;
#(
    parameter int N = REP_COUNT
)
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [N-1:0] req_n,
    input wire logic grant_n,
    input wire logic collision_n,
    input wire logic [N-1:0] rep_dat_oe_n,
    input wire logic bit_clock,
    input wire logic sync_reset_n,
    input wire logic mac_transmit_request_i,
    input wire logic mac_collision_detect_o
);
    // Collision detect lasts at least 95 bit times of 12 clocks.
    localparam int CDT_MIN = 1140;
    logic [N:0] reqs;
    logic [15:0] cdt_len_reg;

    assign reqs = {mac_transmit_request_i, ~req_n};

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            cdt_len_reg <= 16'h0000;
        end
        else if (!mac_collision_detect_o)
        begin
            cdt_len_reg <= 16'h0000;
        end
        else if (cdt_len_reg != 16'hffff)
        begin
            cdt_len_reg <= cdt_len_reg + 16'h0001;
        end
    end

    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);

    // ************************************************************
    // Bit clock halves
    // ************************************************************
    sequence s_high_half;
        bit_clock [*6] ##1 !bit_clock;
    endsequence

    sequence s_low_half;
        !bit_clock [*6] ##1 bit_clock;
    endsequence

    // ************************************************************
    // Checks
    // ************************************************************
    a_grant_single: assert property ($onehot(reqs) && sync_reset_n |=> !grant_n)
        else $error("grant missing for a single request");
    a_idle_release: assert property (reqs == '0 && sync_reset_n |=> grant_n && collision_n)
        else $error("grant or collision without request");
    a_multi_collision: assert property (!$onehot0(reqs) |=> !collision_n && grant_n)
        else $error("several requests without collision");
    a_cdt_follows_col: assert property ($fell(collision_n) |-> ##[1:14] mac_collision_detect_o)
        else $error("collision detect not raised after bus collision");
    a_cdt_min_hold: assert property ($fell(mac_collision_detect_o) |-> cdt_len_reg >= CDT_MIN)
        else $error("collision detect released too early");
    a_cdt_bit_steps: assert property ($changed(mac_collision_detect_o) |=>
        $stable(mac_collision_detect_o) [*8])
        else $error("collision detect changed between bit ticks");
    a_bitclk_high: assert property ($rose(bit_clock) |-> s_high_half)
        else $error("bit clock high half wrong");
    a_bitclk_low: assert property ($fell(bit_clock) |-> s_low_half)
        else $error("bit clock low half wrong");
    a_sync_in_reset: assert property (disable iff (1'b0) !resetn_i |-> !sync_reset_n)
        else $error("synchronous reset not low during reset");
    a_sync_stays_high: assert property (sync_reset_n |=> sync_reset_n)
        else $error("synchronous reset dropped without reset");
    a_bus_quiet: assert property (!grant_n |->
        (~rep_dat_oe_n & req_n & $past(req_n)) == '0)
        else $error("non-requesting repeater drives the data line");
endmodule

// ### inc/xbus_if.sv
`timescale 1ns/1ps
interface xbus_if
    import xbus_pkg::*;
#(
    parameter int N = REP_COUNT
)
(
    input wire logic clk_i
);
    logic [N-1:0] req_n;
    logic grant_n;
    logic collision_n;
    logic [N-1:0] rep_dat_out;
    logic [N-1:0] rep_dat_oe_n;
    logic [N-1:0] rep_jam_out;
    logic [N-1:0] rep_jam_oe_n;
    logic arb_dat_out;
    logic arb_dat_oe_n;
    logic arb_jam_out;
    logic arb_jam_oe_n;
    logic serial_bus_line;
    logic jam_line;
    logic bit_clock;
    logic sync_reset_n;

    // The shared lines read low when nobody drives them.
    assign serial_bus_line = (|(rep_dat_out & ~rep_dat_oe_n)) | (arb_dat_out & ~arb_dat_oe_n);
    assign jam_line = (|(rep_jam_out & ~rep_jam_oe_n)) | (arb_jam_out & ~arb_jam_oe_n);

    modport arbiter (
        input req_n, rep_dat_out, rep_dat_oe_n, rep_jam_out, rep_jam_oe_n,
        input serial_bus_line, jam_line,
        output grant_n, collision_n, arb_dat_out, arb_dat_oe_n, arb_jam_out, arb_jam_oe_n,
        output bit_clock, sync_reset_n
    );

    modport repeaters (
        output req_n, rep_dat_out, rep_dat_oe_n, rep_jam_out, rep_jam_oe_n,
        input serial_bus_line, jam_line,
        input grant_n, collision_n, arb_dat_out, arb_dat_oe_n, arb_jam_out, arb_jam_oe_n,
        input bit_clock, sync_reset_n
    );
endinterface

// ### inc/xbus_pkg.sv
package xbus_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_PERIOD_PS = 8000;
    localparam int BIT_TIME_PS = 100000;
    // Half a bit time in clock cycles, rounded down.
    localparam int HALF_BIT_CYCLES = (BIT_TIME_PS / 2) / CLK_PERIOD_PS;
    localparam int HALF_CNT_W = 4;
    localparam logic [HALF_CNT_W-1:0] HALF_BIT_LAST = HALF_CNT_W'(HALF_BIT_CYCLES - 1);
    localparam logic [HALF_CNT_W-1:0] HALF_BIT_FIRST = 4'h0;

    // ************************************************************
    // Fragment counter
    // ************************************************************
    localparam int FRAG_W = 7;
    localparam logic [FRAG_W-1:0] FRAG_BITS = 7'h60;
    localparam logic [FRAG_W-1:0] FRAG_START = 7'h00;

    // ************************************************************
    // Sizes
    // ************************************************************
    localparam int REP_COUNT = 3;
    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_WIDTH = 1;

    typedef enum logic [2:0] {
        REP_IDLE = 3'b001,
        REP_SEND = 3'b010,
        REP_EXTEND = 3'b100
    } rep_state_type;

endpackage

// ### src/xbus_arbiter.sv
`timescale 1ns/1ps
// Function
// R1: Repeater requests and waits for grant first.
// R2: Grant only when exactly one request active.
// R3: Non-requesting repeaters keep shared lines as inputs.
// R4: MAC transmit request counts like repeater request.
// R5: Multiple requests assert collision; repeaters jam.
// R6: Multiple-request collision also asserts MAC collision.
// R7: Granted requester repeats received data onto bus.
// R8: Bus data is NRZ, already Manchester decoded.
// R9: MAC collision follows bus collision plus repeater cases.
// R10: Hold MAC collision 96 bits after events.
// R11: Fragment counter restarts on every new event.
// R12: Restart pulse; collision held until counter done.
// R13: Early-ending event drops request, extends to 96.
// R14: Generate synchronous reset for repeater devices.
// R15: Bit clock derived in step with reset.
// R16: MAC transmit and receive clocks from bit clock.
// R17: Multiplex MAC transmit and receive onto bus.
// R18: Drive receive enable; receive data on receive clock.
// R19: Counter starts at terminal value after reset.
// R20: Trigger clears counter; counts to terminal, holds.
// R21: All state registered on system clock, divided clock.

// ************************************************************
// Transmit bit buffer
// ************************************************************
module xbus_fifo
    import xbus_pkg::*;
#(
    parameter int WIDTH = FIFO_WIDTH,
    parameter int DEPTH = FIFO_DEPTH
)
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [WIDTH-1:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    output logic [WIDTH-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
    localparam logic [AW:0] EMPTY = '0;

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
    begin : g_check
        $error("xbus_fifo needs a power-of-two depth of at least two");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic [AW:0] fill_reg;
    logic [AW:0] fill_next;
    logic ready_reg;
    logic push;
    logic pop;

    assign push = in_valid_i & ready_reg;
    assign pop = out_ready_i & (fill_reg != EMPTY);
    assign in_ready_o = ready_reg;
    assign out_valid_o = fill_reg != EMPTY;
    assign out_data_o = mem[rd_reg];

    always_comb
    begin
        fill_next = fill_reg;
        if (push && !pop)
        begin
            fill_next = fill_reg + 1'b1;
        end
        else if (pop && !push)
        begin
            fill_next = fill_reg - 1'b1;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (push)
        begin
            mem[wr_reg] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            wr_reg <= '0;
            rd_reg <= '0;
            fill_reg <= EMPTY;
            ready_reg <= 1'b0;
        end
        else
        begin
            wr_reg <= push ? wr_reg + 1'b1 : wr_reg;
            rd_reg <= pop ? rd_reg + 1'b1 : rd_reg;
            fill_reg <= fill_next;
            ready_reg <= fill_next != FULL;
        end
    end
endmodule

// ************************************************************
// Arbiter, fragment counter and MAC interface
// ************************************************************
module xbus_arbiter
    import xbus_pkg::*;
#(
    parameter int N = REP_COUNT
)
(
    input wire logic clk_i,
    input wire logic resetn_i,
    xbus_if.arbiter bus,
    input wire logic mac_transmit_request_i,
    input wire logic mac_tx_serial_i,
    output logic mac_tx_ready_o,
    output logic mac_rx_serial_o,
    output logic mac_receive_enable_o,
    output logic mac_receive_clock_o,
    output logic mac_transmit_clock_o,
    output logic mac_collision_detect_o,
    output logic sync_reset_n_o
);
    if (N < 1)
    begin : g_check
        $error("xbus_arbiter needs at least one repeater");
    end

    logic rst_meta_reg;
    logic rst_sync_reg;
    logic [HALF_CNT_W-1:0] half_reg;
    logic tck_reg;
    logic bit_tick;
    logic [N:0] req_all;
    logic ack;
    logic col;
    logic grant_reg;
    logic collide_reg;
    logic ack_d_reg;
    logic col_d_reg;
    logic rts_d_reg;
    logic cdt_reg;
    logic cdt_next;
    logic xcol_reg;
    logic restart_fragment_timer;
    logic [FRAG_W-1:0] frag_reg;
    logic fragment_timer_done;
    logic mac_src;
    logic rcken_reg;
    logic rx_serial_reg;
    logic rx_en_reg;
    logic rx_clk_reg;
    logic tx_clk_reg;
    logic fifo_data;
    logic fifo_valid;

    // ************************************************************
    // Reset synchroniser and bit clock
    // ************************************************************
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg; // R14
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            half_reg <= HALF_BIT_FIRST;
            tck_reg <= 1'b0;
        end
        else if (!rst_sync_reg)
        begin
            half_reg <= HALF_BIT_FIRST; // R15
            tck_reg <= 1'b0;
        end
        else if (half_reg == HALF_BIT_LAST)
        begin
            half_reg <= HALF_BIT_FIRST; // R21
            tck_reg <= ~tck_reg;
        end
        else
        begin
            half_reg <= half_reg + 1'b1;
        end
    end

    // One pulse per bit, on the rising edge of the bit clock.
    assign bit_tick = rst_sync_reg & (half_reg == HALF_BIT_LAST) & ~tck_reg;

    // ************************************************************
    // Arbitration
    // ************************************************************
    assign req_all = {mac_transmit_request_i, ~bus.req_n}; // R4
    assign ack = (req_all != '0) && ((req_all & (req_all - 1'b1)) == '0); // R2
    assign col = (req_all != '0) && !ack; // R5

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            grant_reg <= 1'b0;
            collide_reg <= 1'b0;
        end
        else
        begin
            grant_reg <= ack & rst_sync_reg; // R2
            collide_reg <= col & rst_sync_reg; // R5
        end
    end

    assign cdt_next = collide_reg // R6 R9
        | (grant_reg & ack_d_reg & bus.jam_line)
        | (col_d_reg & grant_reg)
        | (~fragment_timer_done & cdt_reg); // R10 R12
    assign restart_fragment_timer = bit_tick & ( // R11 R12
        (grant_reg & ~ack_d_reg & ~cdt_reg)
        | (grant_reg & ack_d_reg & bus.jam_line & ~bus.serial_bus_line & ~xcol_reg)
        | (collide_reg & ~xcol_reg));

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            ack_d_reg <= 1'b0;
            col_d_reg <= 1'b0;
            rts_d_reg <= 1'b0;
            cdt_reg <= 1'b0;
            xcol_reg <= 1'b0;
        end
        else if (bit_tick)
        begin
            ack_d_reg <= grant_reg;
            col_d_reg <= collide_reg;
            rts_d_reg <= mac_transmit_request_i;
            cdt_reg <= cdt_next; // R9
            xcol_reg <= (grant_reg & ack_d_reg & bus.jam_line & ~bus.serial_bus_line)
                | collide_reg | (col_d_reg & grant_reg);
        end
    end

    // ************************************************************
    // Fragment counter
    // ************************************************************
    assign fragment_timer_done = frag_reg == FRAG_BITS;

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            frag_reg <= FRAG_BITS; // R19
        end
        else if (!rst_sync_reg)
        begin
            frag_reg <= FRAG_BITS; // R19
        end
        else if (restart_fragment_timer)
        begin
            frag_reg <= FRAG_START; // R11 R20
        end
        else if (bit_tick && !fragment_timer_done)
        begin
            frag_reg <= frag_reg + 1'b1; // R20
        end
    end

    // ************************************************************
    // MAC interface
    // ************************************************************
    assign mac_src = grant_reg & ack_d_reg & rts_d_reg;

    xbus_fifo #(
        .WIDTH(FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) tx_fifo (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .in_data_i(mac_tx_serial_i),
        .in_valid_i(bit_tick & mac_transmit_request_i),
        .in_ready_o(mac_tx_ready_o),
        .out_data_o(fifo_data),
        .out_valid_o(fifo_valid),
        .out_ready_i(bit_tick & mac_src)
    );

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            bus.arb_dat_oe_n <= 1'b1;
            bus.arb_jam_oe_n <= 1'b1;
            bus.arb_dat_out <= 1'b0;
            bus.arb_jam_out <= 1'b0;
        end
        else
        begin
            bus.arb_dat_oe_n <= ~mac_src; // R17
            bus.arb_jam_oe_n <= ~mac_src;
            bus.arb_dat_out <= cdt_reg | (fifo_valid & fifo_data); // R17 R8
            bus.arb_jam_out <= cdt_reg;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rcken_reg <= 1'b0;
            rx_serial_reg <= 1'b0;
        end
        else if (bit_tick)
        begin
            rcken_reg <= (grant_reg & ack_d_reg & ~mac_transmit_request_i & ~rts_d_reg
                & ~bus.jam_line) | (grant_reg & mac_transmit_request_i & ~cdt_reg); // R18
            rx_serial_reg <= (~mac_transmit_request_i & bus.serial_bus_line & grant_reg
                & ack_d_reg) | (mac_tx_serial_i & mac_transmit_request_i); // R17 R18
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rx_en_reg <= 1'b0;
            rx_clk_reg <= 1'b0;
            tx_clk_reg <= 1'b0;
        end
        else
        begin
            rx_en_reg <= (grant_reg & ack_d_reg & ~bus.jam_line & ~cdt_reg) | rcken_reg; // R18
            rx_clk_reg <= rcken_reg & ~tck_reg; // R16
            tx_clk_reg <= tck_reg; // R16
        end
    end

    assign bus.grant_n = ~grant_reg;
    assign bus.collision_n = ~collide_reg;
    assign bus.bit_clock = tck_reg;
    assign bus.sync_reset_n = rst_sync_reg;
    assign mac_rx_serial_o = rx_serial_reg;
    assign mac_receive_enable_o = rx_en_reg;
    assign mac_receive_clock_o = rx_clk_reg;
    assign mac_transmit_clock_o = tx_clk_reg;
    assign mac_collision_detect_o = cdt_reg;
    assign sync_reset_n_o = rst_sync_reg;
endmodule

// ### src/xbus_repeaters.sv
`timescale 1ns/1ps
module xbus_repeaters
    import xbus_pkg::*;
#(
    parameter int N = REP_COUNT
)
(
    input wire logic clk_i,
    input wire logic resetn_i,
    xbus_if.repeaters bus,
    input wire logic [N-1:0] rx_active_i,
    input wire logic [N-1:0] rx_data_i,
    output logic [N-1:0] net_tx_data_o,
    output logic [N-1:0] net_jam_o
);
    if (N < 1)
    begin : g_check
        $error("xbus_repeaters needs at least one repeater");
    end

    logic tck_d_reg;
    logic bit_tick;
    logic [N-1:0] early_drop;
    logic any_early;

    // ************************************************************
    // Bit timing from the arbiter's bit clock
    // ************************************************************
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            tck_d_reg <= 1'b0;
        end
        else
        begin
            tck_d_reg <= bus.bit_clock;
        end
    end

    assign bit_tick = bus.bit_clock & ~tck_d_reg;
    assign any_early = |early_drop;

    // ************************************************************
    // One repeater expansion port per channel
    // ************************************************************
    for (genvar i = 0; i < N; i++)
    begin : g_rep
        rep_state_type state_reg;
        logic [FRAG_W-1:0] bits_reg;
        logic own_grant;

        assign own_grant = ~bus.grant_n & ~bus.req_n[i];
        assign early_drop[i] = bit_tick & (state_reg == REP_SEND) & ~rx_active_i[i]
            & (bits_reg != FRAG_BITS);

        always_ff @(posedge clk_i or negedge resetn_i)
        begin
            if (!resetn_i)
            begin
                state_reg <= REP_IDLE;
                bits_reg <= FRAG_START;
            end
            else if (!bus.sync_reset_n)
            begin
                state_reg <= REP_IDLE;
                bits_reg <= FRAG_START;
            end
            else if (bit_tick)
            begin
                unique case (state_reg)
                    REP_IDLE:
                    begin
                        bits_reg <= FRAG_START;
                        if (any_early)
                        begin
                            state_reg <= REP_EXTEND; // R13
                        end
                        else if (rx_active_i[i])
                        begin
                            state_reg <= REP_SEND;
                        end
                    end
                    REP_SEND:
                    begin
                        if (bits_reg != FRAG_BITS)
                        begin
                            bits_reg <= bits_reg + 1'b1;
                        end
                        if (any_early)
                        begin
                            state_reg <= REP_EXTEND; // R13
                        end
                        else if (!rx_active_i[i])
                        begin
                            state_reg <= REP_IDLE;
                        end
                    end
                    REP_EXTEND:
                    begin
                        if (bits_reg == FRAG_BITS)
                        begin
                            state_reg <= REP_IDLE;
                        end
                        else
                        begin
                            bits_reg <= bits_reg + 1'b1; // R13
                        end
                    end
                endcase
            end
        end

        always_ff @(posedge clk_i or negedge resetn_i)
        begin
            if (!resetn_i)
            begin
                bus.req_n[i] <= 1'b1;
                bus.rep_dat_oe_n[i] <= 1'b1;
                bus.rep_jam_oe_n[i] <= 1'b1;
                bus.rep_dat_out[i] <= 1'b0;
                bus.rep_jam_out[i] <= 1'b0;
                net_tx_data_o[i] <= 1'b0;
                net_jam_o[i] <= 1'b0;
            end
            else
            begin
                bus.req_n[i] <= ~(rx_active_i[i] & (state_reg != REP_EXTEND)); // R1 R13
                bus.rep_dat_oe_n[i] <= ~(own_grant & (state_reg == REP_SEND)); // R1 R3
                bus.rep_jam_oe_n[i] <= ~(own_grant & (state_reg == REP_SEND)); // R3
                bus.rep_dat_out[i] <= rx_data_i[i]; // R7 R8
                bus.rep_jam_out[i] <= 1'b0;
                net_tx_data_o[i] <= bus.serial_bus_line;
                net_jam_o[i] <= ~bus.collision_n | (state_reg == REP_EXTEND); // R5 R13
            end
        end
    end
endmodule
